// File: logic/io_space_pkg.sv
// constants for the low input/output register space
package io_space_pkg;

  localparam int          NUM_RW         = 21;
  localparam int          NUM_FLAG       = 4;
  localparam int          NUM_PIN        = 4;
  localparam logic [5:0]  BIT_SPACE_TOP  = 6'h1f;
  localparam logic [7:0]  DS_IO_BASE     = 8'h20;
  localparam logic [7:0]  DS_IO_TOP      = 8'h5f;
  localparam logic [7:0]  DS_EXT_BASE    = 8'h60;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [7:0]  LOW_NIBBLE     = 8'h0f;

  // plain read/write registers: port offsets and implemented bits
  localparam logic [5:0] RW_OFF [NUM_RW] = '{
    6'h04, 6'h05, 6'h07, 6'h08, 6'h0a, 6'h0b, 6'h0d, 6'h0e, 6'h12,
    6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21, 6'h23, 6'h25, 6'h26, 6'h27,
    6'h28, 6'h2a, 6'h2b};
  localparam logic [7:0] RW_MASK [NUM_RW] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h0f, 8'hff,
    8'h03, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h81, 8'h0f, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff};
  localparam int I_PORT_B_DIR   = 0;
  localparam int I_PORT_B_OUT   = 1;
  localparam int I_PORT_C_DIR   = 2;
  localparam int I_PORT_C_OUT   = 3;
  localparam int I_PORT_D_DIR   = 4;
  localparam int I_PORT_D_OUT   = 5;
  localparam int I_PORT_A_DIR   = 6;
  localparam int I_PORT_A_OUT   = 7;
  localparam int I_PORT_CTRL    = 8;
  localparam int I_EXT_MASK     = 9;
  localparam int I_SCRATCH0     = 10;
  localparam int I_NVM_CTRL     = 11;
  localparam int I_NVM_DATA     = 12;
  localparam int I_NVM_ADDR     = 13;
  localparam int I_GEN_TIMER    = 14;
  localparam int I_T0_CTRL      = 15;
  localparam int I_T0_COUNT     = 16;
  localparam int I_T0_CMP_A     = 17;
  localparam int I_T0_CMP_B     = 18;

  // write-one-to-clear flag registers
  localparam logic [5:0] FLAG_OFF  [NUM_FLAG] = '{6'h15, 6'h16, 6'h1b, 6'h1c};
  localparam logic [7:0] FLAG_MASK [NUM_FLAG] = '{8'h07, 8'h27, 8'h0f, 8'h03};
  localparam int F_TIMER0 = 0;
  localparam int F_TIMER1 = 1;
  localparam int F_PCHG   = 2;
  localparam int F_EXT    = 3;

  // pin input registers, read only: ports b, c, d, a
  localparam logic [5:0] PIN_OFF  [NUM_PIN] = '{6'h03, 6'h06, 6'h09, 6'h0c};
  localparam logic [7:0] PIN_MASK [NUM_PIN] = '{8'hff, 8'hff, 8'hff, 8'h0f};

endpackage : io_space_pkg

// File: logic/reg_cell.sv
// one read/write register with bit set and bit clear
module reg_cell
  import io_space_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hff
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  input  wire logic       bit_set,
  input  wire logic       bit_clr,
  input  wire logic [7:0] bit_onehot,
  output logic      [7:0] q
);

  logic [7:0] next_q;

  assign next_q = wr      ? wdata :
                  bit_set ? (q | bit_onehot) :
                  bit_clr ? (q & ~bit_onehot) : q;

  // unimplemented bits never store anything
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) q <= REG_RESET;
    else        q <= next_q & MASK;
  end

endmodule : reg_cell

// File: logic/flag_cell.sv
// status flags, set by events, cleared by writing one
module flag_cell
  import io_space_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hff
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  input  wire logic       bit_set,
  input  wire logic [7:0] bit_onehot,
  input  wire logic [7:0] evt,
  output logic      [7:0] q
);

  logic [7:0] clr;
  logic [7:0] next_q;

  // bit clear writes zero to one bit, which leaves every flag alone
  assign clr    = wr      ? wdata :
                  bit_set ? bit_onehot : 8'h00;
  // a new event wins over a clear in the same cycle
  assign next_q = (q & ~clr) | evt;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) q <= REG_RESET;
    else        q <= next_q & MASK;
  end

endmodule : flag_cell

// File: logic/io_register_space_decoder.sv
// register file and decoder for the low input/output space
module io_register_space_decoder
  import io_space_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       io_rd,
  input  wire logic       io_wr,
  input  wire logic [5:0] io_addr,
  input  wire logic       ds_rd,
  input  wire logic       ds_wr,
  input  wire logic [7:0] ds_addr,
  input  wire logic [7:0] wdata,
  input  wire logic       set_single_bit_op,
  input  wire logic       clear_single_bit_op,
  input  wire logic       skip_if_bit_set_op,
  input  wire logic       skip_if_bit_clear_op,
  input  wire logic [5:0] bit_addr,
  input  wire logic [2:0] bit_sel,
  input  wire logic [7:0] pin_b,
  input  wire logic [7:0] pin_c,
  input  wire logic [7:0] pin_d,
  input  wire logic [3:0] pin_a,
  input  wire logic [7:0] timer0_evt,
  input  wire logic [7:0] timer1_evt,
  input  wire logic [7:0] pin_change_evt,
  input  wire logic [7:0] ext_irq_evt,
  input  wire logic [7:0] ext_rdata,
  output logic      [7:0] rdata,
  output logic            rd_valid,
  output logic            skip,
  output logic            skip_valid,
  output logic            ext_rd,
  output logic            ext_wr,
  output logic      [7:0] ext_addr,
  output logic      [7:0] ext_wdata,
  output logic      [7:0] port_b_output,
  output logic      [7:0] port_b_direction,
  output logic      [7:0] port_c_output,
  output logic      [7:0] port_c_direction,
  output logic      [7:0] port_d_output,
  output logic      [7:0] port_d_direction,
  output logic      [3:0] port_a_output,
  output logic      [3:0] port_a_direction,
  output logic      [7:0] port_ctrl,
  output logic      [7:0] ext_irq_mask,
  output logic      [7:0] nvm_ctrl,
  output logic      [7:0] nvm_data,
  output logic      [7:0] nvm_addr,
  output logic      [7:0] gen_timer_ctrl,
  output logic      [7:0] timer0_ctrl,
  output logic      [7:0] timer0_count,
  output logic      [7:0] timer0_cmp_a,
  output logic      [7:0] timer0_cmp_b,
  output logic      [7:0] timer0_flags,
  output logic      [7:0] timer1_flags,
  output logic      [7:0] pin_change_flags,
  output logic      [7:0] ext_irq_flags
);

  logic [1:0] rst_sync;
  logic       rst_n;
  logic [7:0] rw_q   [NUM_RW];
  logic [7:0] flag_q [NUM_FLAG];
  logic [7:0] pin_q  [NUM_PIN];
  logic [7:0] flag_evt [NUM_FLAG];
  logic [7:0] pin_raw  [NUM_PIN];
  wire  [8*NUM_RW-1:0] rw_flat;

  // reset is asserted at once and released through two flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) rst_sync <= 2'b00;
    else       rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // one request per cycle: port access, then data space, then bit ops
  wire        port_op  = io_rd | io_wr;
  wire        ds_op    = !port_op && (ds_rd | ds_wr);
  wire        bit_idle = !port_op && !(ds_rd | ds_wr);
  wire        ds_io    = (ds_addr >= DS_IO_BASE) && (ds_addr <= DS_IO_TOP);
  wire        ds_ext   = ds_addr >= DS_EXT_BASE;
  wire        bit_ok   = bit_idle && (bit_addr <= BIT_SPACE_TOP);
  wire [5:0]  ds_port  = 6'(ds_addr - DS_IO_BASE);
  wire [5:0]  acc_addr = port_op ? io_addr : ds_port;
  wire        acc_rd   = io_rd | (ds_op && ds_rd && ds_io);
  wire        acc_wr   = (io_wr && !io_rd)
                         || (ds_op && ds_wr && !ds_rd && ds_io);
  // only the data-space forms reach the extended space
  wire        go_ext_rd = ds_op && ds_rd && ds_ext;
  wire        go_ext_wr = ds_op && ds_wr && !ds_rd && ds_ext;
  wire        bset     = bit_ok && set_single_bit_op;
  wire        bclr     = bit_ok && !set_single_bit_op && clear_single_bit_op;
  wire        btest    = bit_ok && (skip_if_bit_set_op ^ skip_if_bit_clear_op);
  wire [7:0]  onehot   = 8'h01 << bit_sel;

  // any decoded read of the 64-location port space
  function automatic logic [7:0] read_io(input logic [5:0] addr);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < NUM_RW; i++) begin
      if (addr == RW_OFF[i]) v = rw_q[i];
    end
    for (int i = 0; i < NUM_FLAG; i++) begin
      if (addr == FLAG_OFF[i]) v = flag_q[i];
    end
    for (int i = 0; i < NUM_PIN; i++) begin
      if (addr == PIN_OFF[i]) v = pin_q[i];
    end
    return v;
  endfunction : read_io

  logic [7:0] acc_data;
  logic [7:0] test_reg;
  // a block, not an assign: the register reads hide inside the function
  always_comb begin
    acc_data = read_io(acc_addr);
    test_reg = read_io(bit_addr);
  end
  wire       test_bit = test_reg[bit_sel];
  // skip when the bit matches the sense that the op asks for
  wire       next_skip = skip_if_bit_set_op ? test_bit : !test_bit;

  genvar g;
  generate
    for (g = 0; g < NUM_RW; g++) begin : g_rw
      reg_cell #(.MASK(RW_MASK[g])) u_reg (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .wr         (acc_wr && acc_addr == RW_OFF[g]),
        .wdata      (wdata),
        .bit_set    (bset && bit_addr == RW_OFF[g]),
        .bit_clr    (bclr && bit_addr == RW_OFF[g]),
        .bit_onehot (onehot),
        .q          (rw_q[g])
      );
      assign rw_flat[8*g +: 8] = rw_q[g];
    end
    for (g = 0; g < NUM_FLAG; g++) begin : g_flag
      flag_cell #(.MASK(FLAG_MASK[g])) u_flag (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .wr         (acc_wr && acc_addr == FLAG_OFF[g]),
        .wdata      (wdata),
        .bit_set    (bset && bit_addr == FLAG_OFF[g]),
        .bit_onehot (onehot),
        .evt        (flag_evt[g]),
        .q          (flag_q[g])
      );
    end
  endgenerate

  assign flag_evt[F_TIMER0] = timer0_evt;
  assign flag_evt[F_TIMER1] = timer1_evt;
  assign flag_evt[F_PCHG]   = pin_change_evt;
  assign flag_evt[F_EXT]    = ext_irq_evt;
  assign pin_raw[0]         = pin_b;
  assign pin_raw[1]         = pin_c;
  assign pin_raw[2]         = pin_d;
  assign pin_raw[3]         = {4'h0, pin_a};

  // pin registers are sampled copies; writes to them are dropped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_PIN; i++) pin_q[i] <= REG_RESET;
    end else begin
      for (int i = 0; i < NUM_PIN; i++) pin_q[i] <= pin_raw[i] & PIN_MASK[i];
    end
  end

  // answers one cycle after the request, extended reads one more
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata      <= 8'h00;
      rd_valid   <= 1'b0;
      skip       <= 1'b0;
      skip_valid <= 1'b0;
    end else begin
      rdata      <= ext_rd ? ext_rdata : acc_data;
      rd_valid   <= acc_rd | ext_rd;
      skip       <= btest & next_skip;
      skip_valid <= btest;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_rd    <= 1'b0;
      ext_wr    <= 1'b0;
      ext_addr  <= 8'h00;
      ext_wdata <= 8'h00;
    end else begin
      ext_rd    <= go_ext_rd;
      ext_wr    <= go_ext_wr;
      ext_addr  <= ds_addr;
      ext_wdata <= wdata;
    end
  end

  assign port_b_direction = rw_q[I_PORT_B_DIR];
  assign port_b_output    = rw_q[I_PORT_B_OUT];
  assign port_c_direction = rw_q[I_PORT_C_DIR];
  assign port_c_output    = rw_q[I_PORT_C_OUT];
  assign port_d_direction = rw_q[I_PORT_D_DIR];
  assign port_d_output    = rw_q[I_PORT_D_OUT];
  assign port_a_direction = rw_q[I_PORT_A_DIR][3:0];
  assign port_a_output    = rw_q[I_PORT_A_OUT][3:0];
  assign port_ctrl        = rw_q[I_PORT_CTRL];
  assign ext_irq_mask     = rw_q[I_EXT_MASK];
  assign nvm_ctrl         = rw_q[I_NVM_CTRL];
  assign nvm_data         = rw_q[I_NVM_DATA];
  assign nvm_addr         = rw_q[I_NVM_ADDR];
  assign gen_timer_ctrl   = rw_q[I_GEN_TIMER];
  assign timer0_ctrl      = rw_q[I_T0_CTRL];
  assign timer0_count     = rw_q[I_T0_COUNT];
  assign timer0_cmp_a     = rw_q[I_T0_CMP_A];
  assign timer0_cmp_b     = rw_q[I_T0_CMP_B];
  assign timer0_flags     = flag_q[F_TIMER0];
  assign timer1_flags     = flag_q[F_TIMER1];
  assign pin_change_flags = flag_q[F_PCHG];
  assign ext_irq_flags    = flag_q[F_EXT];

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  wire [5:0] scratch_off = RW_OFF[I_SCRATCH0];
  wire [5:0] ext_off     = FLAG_OFF[F_EXT];

  sequence scratch_bit_set_s;
    bset && bit_addr == scratch_off;
  endsequence
  sequence scratch_bit_clr_s;
    bclr && bit_addr == scratch_off;
  endsequence

  bit_set_a : assert property (
    scratch_bit_set_s |=> rw_q[I_SCRATCH0][$past(bit_sel)])
    else $error("bit set did not set the bit");
  bit_clr_a : assert property (
    scratch_bit_clr_s |=> !rw_q[I_SCRATCH0][$past(bit_sel)])
    else $error("bit clear did not clear the bit");
  skip_sense_a : assert property (
    btest |=> skip_valid && skip == $past(next_skip))
    else $error("skip answer wrong");
  flag_clear_a : assert property (
    io_wr && !io_rd && io_addr == ext_off && wdata[0] && !ext_irq_evt[0]
    |=> !ext_irq_flags[0])
    else $error("writing one did not clear flag");
  flag_keep_a : assert property (
    io_wr && !io_rd && io_addr == ext_off && wdata == 8'h00
    |=> ext_irq_flags == $past(ext_irq_flags))
    else $error("writing zero changed flags");
  bitop_only_a : assert property (
    bit_ok && bit_addr == ext_off && bit_sel == 3'd1
    |=> ext_irq_flags[0] == $past(ext_irq_flags[0]) || $past(ext_irq_evt[0]))
    else $error("bit op cleared another flag");
  high_bitop_a : assert property (
    bit_idle && bit_addr > BIT_SPACE_TOP |=> !skip_valid ##0 $stable(rw_flat))
    else $error("bit op honoured above bit space");
  ds_map_a : assert property (
    ds_wr && !ds_rd && !port_op
    && ds_addr == 8'({2'b00, scratch_off}) + DS_IO_BASE
    |=> rw_q[I_SCRATCH0] == $past(wdata))
    else $error("data-space write missed register");
  io_no_ext_a : assert property (
    port_op |=> !ext_rd && !ext_wr)
    else $error("port access reached extended space");
  ext_read_a : assert property (
    go_ext_rd |=> ext_rd ##1 rd_valid && rdata == $past(ext_rdata))
    else $error("extended read answer wrong");
  port_a_bits_a : assert property (
    rw_q[I_PORT_A_OUT][7:4] == 4'h0 && pin_q[3][7:4] == 4'h0)
    else $error("port a upper bits stored");
  port_d_full_a : assert property (
    io_wr && !io_rd && io_addr == RW_OFF[I_PORT_D_OUT]
    |=> port_d_output == $past(wdata))
    else $error("port d output not 8 bits");
  reserved_read_a : assert property (
    io_rd && io_addr == 6'h00 |=> rd_valid && rdata == 8'h00)
    else $error("reserved address read nonzero");

  // flag, pin, port, skip, data-space and extended-space checks
  sequence ext_flag_clr_s;
    bclr && bit_addr == ext_off;
  endsequence
  sequence low_ds_s;
    ds_op && ds_addr < DS_IO_BASE && !ext_rd;
  endsequence

  evt_wins_a : assert property (
    ext_irq_evt[0] |=> ext_irq_flags[0])
    else $error("flag event lost to a clear");
  flag_bclr_a : assert property (
    ext_flag_clr_s |=> ext_irq_flags ==
      ($past(ext_irq_flags) | ($past(ext_irq_evt) & FLAG_MASK[F_EXT])))
    else $error("bit clear changed a flag");
  skip_only_a : assert property (
    skip_valid |-> $past(btest))
    else $error("skip answer without a bit test");
  port_rd_a : assert property (
    io_rd |=> rd_valid)
    else $error("port read not answered");
  port_b_wr_a : assert property (
    io_wr && !io_rd && io_addr == RW_OFF[I_PORT_B_OUT]
    |=> port_b_output == $past(wdata))
    else $error("port write missed register");
  ds_read_a : assert property (
    ds_op && ds_rd && ds_io |=> rd_valid)
    else $error("data-space read not answered");
  ext_write_a : assert property (
    go_ext_wr |=> ext_wr && ext_addr == $past(ds_addr)
    && ext_wdata == $past(wdata))
    else $error("extended write not forwarded");
  port_a_dir_a : assert property (
    rw_q[I_PORT_A_DIR][7:4] == 4'h0)
    else $error("port a direction upper bits stored");
  pin_follow_a : assert property (
    $past(rst_n) |-> pin_q[2] == $past(pin_d))
    else $error("port d pins not sampled");
  low_ds_a : assert property (
    low_ds_s |=> !rd_valid && !ext_rd && !ext_wr)
    else $error("low data address answered");
  mask_bits_a : assert property (
    (rw_q[I_EXT_MASK] & ~RW_MASK[I_EXT_MASK]) == 8'h00
    && (timer1_flags & ~FLAG_MASK[F_TIMER1]) == 8'h00)
    else $error("unimplemented bits stored");

endmodule : io_register_space_decoder

// File: verif/ext_space_model.sv
// behavioural model of the extended register space
module ext_space_model
  import io_space_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       ext_rd,
  input  wire logic       ext_wr,
  input  wire logic [7:0] ext_addr,
  input  wire logic [7:0] ext_wdata,
  output logic      [7:0] ext_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256] = '{default: 8'h00};
  logic [7:0] last      = 8'h00;
  // stores land on the edge that takes the strobe
  always @(posedge ref_clk) begin
    if (ext_wr === 1'b1) mem[ext_addr] <= ext_wdata;
    if (ext_rd === 1'b1) last <= mem[ext_addr];
  end
  // idle bus shows the inverse of the last value, so a late sample fails
  assign ext_rdata = ext_rd ? mem[ext_addr] : ~last;
endmodule : ext_space_model

// File: verif/test_io_register_space_decoder.sv
// self-checking bench for the io register space decoder
module test_io_register_space_decoder
  import io_space_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk, rstn, io_rd, io_wr, ds_rd, ds_wr, rd_valid;
  logic       set_single_bit_op, clear_single_bit_op, skip, skip_valid;
  logic       skip_if_bit_set_op, skip_if_bit_clear_op, ext_rd, ext_wr;
  logic [5:0] io_addr, bit_addr;
  logic [2:0] bit_sel;
  logic [3:0] pin_a, port_a_output, port_a_direction;
  logic [7:0] ds_addr, wdata, pin_b, pin_c, pin_d, ext_rdata, rdata;
  logic [7:0] timer0_evt, timer1_evt, pin_change_evt, ext_irq_evt;
  logic [7:0] ext_addr, ext_wdata, port_d_output, timer0_flags;
  logic [7:0] timer1_flags, pin_change_flags, ext_irq_flags;
  logic [7:0] port_b_output, port_b_direction, port_c_output, port_ctrl;
  logic [7:0] port_c_direction, port_d_direction, ext_irq_mask, nvm_ctrl;
  logic [7:0] nvm_data, nvm_addr, gen_timer_ctrl, timer0_ctrl;
  logic [7:0] timer0_count, timer0_cmp_a, timer0_cmp_b;
  int         failures, checks;

  io_register_space_decoder io_register_space_decoder_inst (
    .ref_clk, .rstn, .io_rd, .io_wr, .io_addr, .ds_rd, .ds_wr, .ds_addr,
    .wdata, .set_single_bit_op, .clear_single_bit_op,
    .skip_if_bit_set_op, .skip_if_bit_clear_op, .bit_addr, .bit_sel,
    .pin_b, .pin_c, .pin_d, .pin_a, .timer0_evt, .timer1_evt,
    .pin_change_evt, .ext_irq_evt, .ext_rdata, .rdata, .rd_valid, .skip,
    .skip_valid, .ext_rd, .ext_wr, .ext_addr, .ext_wdata,
    .port_b_output, .port_b_direction, .port_c_output,
    .port_c_direction, .port_d_output, .port_d_direction,
    .port_a_output, .port_a_direction, .port_ctrl, .ext_irq_mask,
    .nvm_ctrl, .nvm_data, .nvm_addr, .gen_timer_ctrl,
    .timer0_ctrl, .timer0_count, .timer0_cmp_a, .timer0_cmp_b,
    .timer0_flags, .timer1_flags, .pin_change_flags, .ext_irq_flags);

  ext_space_model ext_space_model_inst (
    .ref_clk, .ext_rd, .ext_wr, .ext_addr, .ext_wdata, .ext_rdata);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // m: writable bits, p: what a read returns from pins, ok: not reserved
  function automatic void info(input logic [5:0] a, output logic [7:0] m,
                               output logic [7:0] p, output bit ok);
    logic [7:0] pins [NUM_PIN];
    pins = '{pin_b, pin_c, pin_d, {4'h0, pin_a}};
    {m, p, ok} = 17'h0;
    for (int i = 0; i < NUM_RW; i++)
      if (RW_OFF[i] == a) {m, ok} = {RW_MASK[i], 1'b1};
    for (int i = 0; i < NUM_PIN; i++)
      if (PIN_OFF[i] == a) {p, ok} = {pins[i] & PIN_MASK[i], 1'b1};
    for (int i = 0; i < NUM_FLAG; i++)
      if (FLAG_OFF[i] == a) ok = 1'b1;
  endfunction : info

  // kind: 0 port write, 1 port read, 2 data write, 3 data read
  task automatic acc(int kind, logic [7:0] a, logic [7:0] v, bit ans,
                     output logic [7:0] d);
    bit got;
    got = 1'b0;
    d = 8'h00;
    @(posedge ref_clk);
    {io_wr, io_rd, ds_wr, ds_rd} <= 4'b1000 >> kind;
    io_addr <= a[5:0];
    ds_addr <= a;
    wdata <= v;
    @(posedge ref_clk);
    {io_wr, io_rd, ds_wr, ds_rd} <= 4'h0;
    if (kind % 2 == 0) @(negedge ref_clk);
    else begin
      // extended reads answer a cycle later, so allow a few cycles
      for (int i = 0; i < 4 && !got; i++) begin
        @(negedge ref_clk);
        if (rd_valid === 1'b1) {got, d} = {1'b1, rdata};
      end
      chk("answer", {7'h00, ans}, {7'h00, got});
      if (ans && !got) end_sim();
    end
  endtask : acc

  task automatic rdchk(bit ds, logic [5:0] a, logic [7:0] exp);
    logic [7:0] d;
    acc(ds ? 3 : 1, {2'b00, a} + (ds ? DS_IO_BASE : 8'h00), 8'h00, 1'b1, d);
    chk("read data", exp, d);
  endtask : rdchk

  // kind: 0 set, 1 clear, 2 skip if set, 3 skip if clear
  task automatic bop(int kind, logic [5:0] a, logic [2:0] s,
                     output logic [1:0] r);
    @(posedge ref_clk);
    {set_single_bit_op, clear_single_bit_op, skip_if_bit_set_op,
     skip_if_bit_clear_op} <= 4'b1000 >> kind;
    bit_addr <= a;
    bit_sel <= s;
    @(posedge ref_clk);
    {set_single_bit_op, clear_single_bit_op, skip_if_bit_set_op,
     skip_if_bit_clear_op} <= 4'h0;
    @(negedge ref_clk);
    r = {skip_valid, skip};
  endtask : bop

  task automatic t_map_reset();
    logic [7:0] m, p;
    bit ok;
    for (int n = 0; n < 64; n++) begin
      info(6'(n), m, p, ok);
      rdchk(1'b0, 6'(n), p);
    end
    $display("map after reset done");
  endtask : t_map_reset

  task automatic t_write_read();
    logic [7:0] m, p, d, v, x;
    logic [5:0] a;
    bit ok;
    logic [7:0] outs [I_T0_CMP_B + 1];
    for (int n = 0; n < 128; n++) begin
      a = 6'(n);
      info(a, m, p, ok);
      v = (n < 64 ? 8'ha5 : 8'h5a) & m;
      x = {2'b00, a} + (n < 64 ? DS_IO_BASE : 8'h00);
      if (ok) acc(n < 64 ? 2 : 0, x, v, 1'b0, d);
      rdchk(n >= 64, a, v | p);
    end
    chk("port d out", 8'h5a, port_d_output);
    chk("port a out", 8'h0a, {4'h0, port_a_output});
    // index order of the package; the scratch slot has no output pin
    outs = '{port_b_direction, port_b_output, port_c_direction,
             port_c_output, port_d_direction, port_d_output,
             {4'h0, port_a_direction}, {4'h0, port_a_output}, port_ctrl,
             ext_irq_mask, 8'h00, nvm_ctrl, nvm_data, nvm_addr,
             gen_timer_ctrl, timer0_ctrl, timer0_count, timer0_cmp_a,
             timer0_cmp_b};
    for (int i = 0; i <= I_T0_CMP_B; i++)
      if (i != I_SCRATCH0)
        chk($sformatf("output %0d", i), 8'h5a & RW_MASK[i], outs[i]);
    $display("write and read back done");
  endtask : t_write_read

  task automatic t_bit_ops();
    logic [7:0] d;
    logic [1:0] r;
    acc(0, 8'h0b, 8'h00, 1'b0, d);
    acc(0, 8'h20, 8'h5a, 1'b0, d);
    acc(0, 8'h1f, 8'h00, 1'b0, d);
    bop(0, 6'h0b, 3'd7, r);
    bop(0, 6'h0b, 3'd0, r);
    chk("port d out", 8'h81, port_d_output);
    bop(1, 6'h0b, 3'd7, r);
    chk("port d out", 8'h01, port_d_output);
    for (int i = 0; i < 4; i++) begin
      bop(2 + i / 2, 6'h0b, 3'(i % 2), r);
      chk("skip", {6'h00, 1'b1, i == 0 || i == 3}, {6'h00, r});
    end
    bop(3, 6'h09, 3'd0, r);
    chk("pin skip", 8'h03, {6'h00, r});
    bop(0, 6'h1f, 3'd5, r);
    rdchk(1'b0, 6'h1f, 8'h20);
    bop(0, 6'h20, 3'd0, r);
    rdchk(1'b0, 6'h20, 8'h5a);
    bop(2, 6'h20, 3'd1, r);
    chk("skip valid", 8'h00, {7'h00, r[1]});
    bop(0, 6'h1e, 3'd2, r);
    rdchk(1'b0, 6'h1e, 8'h5e);
    bop(1, 6'h1e, 3'd6, r);
    rdchk(1'b0, 6'h1e, 8'h1e);
    $display("bit operations done");
  endtask : t_bit_ops

  task automatic t_flags();
    logic [7:0] d;
    logic [1:0] r;
    @(posedge ref_clk);
    {timer0_evt, timer1_evt, pin_change_evt, ext_irq_evt} <= '1;
    @(posedge ref_clk);
    {timer0_evt, timer1_evt, pin_change_evt, ext_irq_evt} <= '0;
    @(negedge ref_clk);
    chk("timer0 flags", 8'h07, timer0_flags);
    chk("timer1 flags", 8'h27, timer1_flags);
    chk("change flags", 8'h0f, pin_change_flags);
    chk("ext flags", 8'h03, ext_irq_flags);
    acc(0, 8'h15, 8'h02, 1'b0, d);
    chk("timer0 flags", 8'h05, timer0_flags);
    acc(0, 8'h15, 8'h00, 1'b0, d);
    chk("timer0 flags", 8'h05, timer0_flags);
    bop(0, 6'h15, 3'd0, r);
    chk("timer0 flags", 8'h04, timer0_flags);
    bop(1, 6'h15, 3'd2, r);
    chk("timer0 flags", 8'h04, timer0_flags);
    acc(2, 8'h36, 8'hff, 1'b0, d);
    chk("timer1 flags", 8'h00, timer1_flags);
    bop(3, 6'h1c, 3'd1, r);
    chk("flag skip", 8'h02, {6'h00, r});
    bop(1, 6'h1c, 3'd0, r);
    chk("ext flags", 8'h03, ext_irq_flags);
    bop(0, 6'h1c, 3'd1, r);
    chk("ext flags", 8'h01, ext_irq_flags);
    acc(0, 8'h1c, 8'h01, 1'b0, d);
    chk("ext flags", 8'h00, ext_irq_flags);
    $display("status flags done");
  endtask : t_flags

  task automatic t_ext();
    logic [7:0] d;
    acc(2, 8'h60, 8'h3c, 1'b0, d);
    acc(2, 8'hff, 8'hc3, 1'b0, d);
    acc(3, 8'h60, 8'h00, 1'b1, d);
    chk("ext read", 8'h3c, d);
    acc(3, 8'hff, 8'h00, 1'b1, d);
    chk("ext read", 8'hc3, d);
    acc(3, 8'h10, 8'h00, 1'b0, d);
    $display("extended space done");
  endtask : t_ext

  initial begin
    failures = 0;
    checks = 0;
    rstn = 1'b0;
    {io_rd, io_wr, ds_rd, ds_wr} = 4'h0;
    {set_single_bit_op, clear_single_bit_op} = 2'b00;
    {skip_if_bit_set_op, skip_if_bit_clear_op} = 2'b00;
    {io_addr, bit_addr, bit_sel} = 15'h0000;
    {ds_addr, wdata} = 16'h0000;
    {timer0_evt, timer1_evt, pin_change_evt, ext_irq_evt} = 32'h0;
    {pin_b, pin_c, pin_d, pin_a} = 28'ha53c969;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_map_reset();
    t_write_read();
    t_bit_ops();
    t_flags();
    t_ext();
    end_sim();
  end
endmodule : test_io_register_space_decoder
